// ==== data_mem_defs.vh ====
/*
 * constants for the internal data memory decoder: address map, bank and bit area
 * layout, flash sector geometry, access mode codes. assumes an 8-bit internal data space.
 */
`ifndef DATA_MEM_DEFS_VH
`define DATA_MEM_DEFS_VH
`define RAM_DEPTH 256
`define RAM_AW 8
`define UPPER_BIT 7
`define BANK_TOP 8'h1F
`define BITAREA_BASE 8'h20
`define BITAREA_TOP 8'h2F
`define BITADDR_SFR_BIT 7
`define SECTOR_BYTES 1024
`define SECTOR_AW 10
`define FLASH_AW 15
`define FLASH_ERASED 8'hFF
`define PSW_ADDR 8'hD0
`define PSW_BANK_LO 3
`define PSW_BANK_HI 4
`define MODE_DIRECT 2'h0
`define MODE_INDIRECT 2'h1
`define MODE_REGISTER 2'h2
`define MODE_BIT 2'h3
`endif

// ==== data_ram.v ====
/*
 * single-port byte RAM with registered read data.
 * assumes one access per cycle; write and read of one address return the old byte.
 */
`timescale 1ns/1ps
`include "data_mem_defs.vh"
module data_ram (
    input wire clk,
    input wire we,
    input wire [`RAM_AW-1:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:`RAM_DEPTH-1];
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // data_ram

// ==== data_mem_decode.v ====
/*
 * internal data memory decode: routes core accesses to ram or the sfr space,
 * resolves working register banks and bit addresses, sequences sector erase.
 * assumes the core holds request lines for one cycle and the sfr side and flash
 * array answer combinationally outside this block.
 */
`timescale 1ns/1ps
`include "data_mem_defs.vh"
// What this block does
// - there are 256 bytes of data ram whose upper 128 share addresses with the sfr space.
// - indirect accesses to the upper half reach general purpose ram.
// - direct accesses to the upper half reach the sfr space, not ram.
// - direct and indirect accesses to the lower half reach the same ram bytes.
// - the lowest 32 bytes form four banks of eight working registers.
// - the 16 bytes above the banks can be reached as bytes or as single bits.
// - flash is erased in 1024-byte sectors with no outside programming voltage.
module data_mem_decode (
    input wire core_clk,
    input wire nrst,
    input wire req,
    input wire we,
    input wire [1:0] mode,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire [7:0] sfr_rdata,
    input wire erase_req,
    input wire [`FLASH_AW-1:0] erase_addr,
    output reg [7:0] rdata,
    output reg rvalid,
    output reg sfr_req,
    output reg sfr_we,
    output reg [7:0] sfr_addr,
    output reg [7:0] sfr_wdata,
    output reg [1:0] bank_sel,
    output reg flash_we,
    output reg [`FLASH_AW-1:0] flash_addr,
    output reg [7:0] flash_wdata,
    output reg erase_busy,
    output reg erase_done
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ERASE = 1'b1;
    // sector size is a power of two, so the last offset is all ones at counter width
    localparam [`SECTOR_AW-1:0] SECTOR_LAST = {`SECTOR_AW{1'b1}};

    reg rst_s1_q;
    reg rst_n_q;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // bit addresses 0..127 map onto bytes of the bit area, bit in low three bits
    function [7:0] bit_byte;
        input [7:0] a;
        begin
            bit_byte = `BITAREA_BASE + {4'h0, a[6:3]};
        end
    endfunction

    function is_upper;
        input [7:0] a;
        begin
            is_upper = a[`UPPER_BIT];
        end
    endfunction

    reg to_sfr;
    reg [7:0] ram_addr;
    reg is_bit_d;
    always @* begin
        to_sfr = 1'b0;
        ram_addr = addr;
        is_bit_d = 1'b0;
        case (mode)
            `MODE_DIRECT: begin
                to_sfr = is_upper(addr);
            end
            `MODE_INDIRECT: begin
                to_sfr = 1'b0;
            end
            `MODE_REGISTER: begin
                ram_addr = {3'b000, bank_sel, addr[2:0]};
            end
            `MODE_BIT: begin
                // bit addresses with the top bit set belong to bit-addressable sfrs
                if (addr[`BITADDR_SFR_BIT]) begin
                    to_sfr = 1'b1;
                    ram_addr = {addr[7:3], 3'b000};
                end else begin
                    is_bit_d = 1'b1;
                    ram_addr = bit_byte(addr);
                end
            end
            default: begin
                to_sfr = 1'b0;
            end
        endcase
    end

    // bit writes to the ram bit area are read-modify-write, so they cost a read cycle first
    reg rmw_q;
    reg [7:0] rmw_addr_q;
    reg [2:0] rmw_bit_q;
    reg rmw_val_q;
    reg pend_q;
    reg pend_sfr_q;
    reg pend_bit_q;
    reg [2:0] pend_bitn_q;

    wire ram_we = (req && we && !to_sfr && !is_bit_d) || rmw_q;
    wire [7:0] ram_a = rmw_q ? rmw_addr_q : ram_addr;
    wire [7:0] ram_q;
    reg [7:0] rmw_data;
    integer i;
    always @* begin
        rmw_data = ram_q;
        for (i = 0; i < 8; i = i + 1) begin
            if (rmw_bit_q == i[2:0]) begin
                rmw_data[i] = rmw_val_q;
            end
        end
    end
    wire [7:0] ram_wd = rmw_q ? rmw_data : wdata;

    data_ram u_ram (
        .clk(core_clk),
        .we(ram_we),
        .addr(ram_a),
        .wdata(ram_wd),
        .rdata(ram_q)
    );

    // register-operand bank follows the psw write that goes out to the sfr space
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bank_sel <= 2'b00;
            sfr_req <= 1'b0;
            sfr_we <= 1'b0;
            sfr_addr <= 8'h00;
            sfr_wdata <= 8'h00;
            rmw_q <= 1'b0;
            rmw_addr_q <= 8'h00;
            rmw_bit_q <= 3'b000;
            rmw_val_q <= 1'b0;
            pend_q <= 1'b0;
            pend_sfr_q <= 1'b0;
            pend_bit_q <= 1'b0;
            pend_bitn_q <= 3'b000;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            sfr_req <= req && to_sfr;
            sfr_we <= req && to_sfr && we;
            if (req && to_sfr) begin
                sfr_addr <= ram_addr;
                sfr_wdata <= wdata;
            end
            if (req && to_sfr && we && ram_addr == `PSW_ADDR) begin
                bank_sel <= wdata[`PSW_BANK_HI:`PSW_BANK_LO];
            end
            rmw_q <= req && we && is_bit_d;
            if (req && we && is_bit_d) begin
                rmw_addr_q <= ram_addr;
                rmw_bit_q <= addr[2:0];
                rmw_val_q <= wdata[0];
            end
            pend_q <= req && !we;
            pend_sfr_q <= to_sfr;
            pend_bit_q <= is_bit_d;
            pend_bitn_q <= addr[2:0];
            rvalid <= pend_q;
            if (pend_q) begin
                if (pend_sfr_q) begin
                    rdata <= sfr_rdata;
                end else if (pend_bit_q) begin
                    rdata <= {7'h00, ram_q[pend_bitn_q]};
                end else begin
                    rdata <= ram_q;
                end
            end
        end
    end

    // sector erase: walks every byte of the sector writing the erased value
    reg state_q;
    reg [`SECTOR_AW-1:0] cnt_q;
    always @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            cnt_q <= {`SECTOR_AW{1'b0}};
            flash_we <= 1'b0;
            flash_addr <= {`FLASH_AW{1'b0}};
            flash_wdata <= `FLASH_ERASED;
            erase_busy <= 1'b0;
            erase_done <= 1'b0;
        end else begin
            erase_done <= 1'b0;
            flash_we <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (erase_req) begin
                        state_q <= ST_ERASE;
                        erase_busy <= 1'b1;
                        cnt_q <= {`SECTOR_AW{1'b0}};
                        flash_addr <= {erase_addr[`FLASH_AW-1:`SECTOR_AW],
                            {`SECTOR_AW{1'b0}}};
                    end
                end
                ST_ERASE: begin
                    flash_we <= 1'b1;
                    flash_wdata <= `FLASH_ERASED;
                    flash_addr <= {flash_addr[`FLASH_AW-1:`SECTOR_AW], cnt_q};
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == SECTOR_LAST) begin
                        state_q <= ST_IDLE;
                        erase_busy <= 1'b0;
                        erase_done <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // data_mem_decode

// ==== data_mem_decode_assertions.sv ====
/* port checker for data_mem_decode. assumes the bind below and one core_clk domain. */
`timescale 1ns/1ps
module data_mem_decode_checker (
    input wire core_clk,
    input wire nrst,
    input wire req,
    input wire we,
    input wire [1:0] mode,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire erase_req,
    input wire rvalid,
    input wire sfr_req,
    input wire sfr_we,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire flash_we,
    input wire [14:0] flash_addr,
    input wire [7:0] flash_wdata,
    input wire erase_busy,
    input wire erase_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    chk_direct_sfr: assert property (
        req && mode == 2'h0 && addr[7] |=> sfr_req && sfr_addr == $past(addr)) else $error("no sfr");
    chk_sfr_write: assert property (
        req && we && mode == 2'h0 && addr[7] |=> sfr_we && sfr_wdata == $past(wdata))
        else $error("sfr write");
    chk_ram_only: assert property (
        req && (mode == 2'h1 || mode == 2'h2 || !addr[7]) |=> !sfr_req) else $error("stray sfr");
    chk_bit_sfr: assert property (
        req && mode == 2'h3 && addr[7] |=> sfr_req && sfr_addr == ($past(addr) & 8'hF8))
        else $error("bit sfr");
    chk_read_answer: assert property (req && !we |-> ##2 rvalid) else $error("no rvalid");
    chk_erase_start: assert property (
        erase_req && !erase_busy |=> erase_busy) else $error("no busy");
    chk_erase_fill: assert property (flash_we |-> flash_wdata == 8'hFF) else $error("fill");
    chk_erase_end: assert property (
        erase_done |-> flash_we && flash_addr[9:0] == 10'h3FF) else $error("bad end");
endmodule // data_mem_decode_checker
bind data_mem_decode data_mem_decode_checker u_chk (.core_clk, .nrst, .req, .we, .mode, .addr,
    .wdata, .erase_req, .rvalid, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata, .flash_we,
    .flash_addr, .flash_wdata, .erase_busy, .erase_done);

// ==== sfr_model.sv ====
/* sfr space model behind the decoder. assumes answers combinational while sfr_req is high. */
`timescale 1ns/1ps
module sfr_model (
    input wire core_clk,
    input wire sfr_req,
    input wire sfr_we,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    output wire [7:0] sfr_rdata
);
    reg [7:0] mem [0:127];
    reg [7:0] last_q = 8'h00;
    // idle bus shows the inverse of the last byte, so stale data never passes
    assign sfr_rdata = sfr_req ? mem[sfr_addr[6:0]] : ~last_q;
    always @(posedge core_clk) begin
        if (sfr_req && sfr_we) mem[sfr_addr[6:0]] <= sfr_wdata;
        if (sfr_req) last_q <= mem[sfr_addr[6:0]];
    end
endmodule // sfr_model

// ==== tb_internal_data_memory_decode.sv ====
/* self-checking bench for data_mem_decode. assumes sfr_model and the bound checker. */
`timescale 1ns/1ps
module tb_internal_data_memory_decode;
    reg core_clk = 0, nrst = 0, req = 0, we = 0, erase_req = 0;
    reg [1:0] mode = 0;
    reg [7:0] addr = 0, wdata = 0;
    reg [14:0] erase_addr = 0;
    wire [7:0] sfr_rdata, rdata, sfr_addr, sfr_wdata, flash_wdata;
    wire rvalid, sfr_req, sfr_we, flash_we, erase_busy, erase_done;
    wire [1:0] bank_sel;
    wire [14:0] flash_addr;
    reg [7:0] ram [0:255];
    reg [7:0] sfr [0:255];
    logic [7:0] expq [$];
    integer failures = 0, samples_checked = 0, i, n, b, k;
    always #2 core_clk = ~core_clk;
    data_mem_decode u_dut (.core_clk, .nrst, .req, .we, .mode, .addr, .wdata, .sfr_rdata,
        .erase_req, .erase_addr, .rdata, .rvalid, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata,
        .bank_sel, .flash_we, .flash_addr, .flash_wdata, .erase_busy, .erase_done);
    sfr_model u_sfr (.core_clk, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata, .sfr_rdata);
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // request held one cycle; caller sits just after an edge
    task acc(input w, input [1:0] m, input [7:0] a, input [7:0] d, input [7:0] e);
        req = 1;
        we = w;
        mode = m;
        addr = a;
        wdata = d;
        if (!w) expq.push_back(e);
        @(posedge core_clk);
        #1;
    endtask
    task idle(input integer c);
        req = 0;
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk) if (rvalid === 1'b1)
        check(rdata, expq.size() ? expq.pop_front() : 16'hdead);
    initial begin
        n = $urandom(8);
        repeat (5) @(posedge core_clk);
        #1 nrst = 1;
        idle(3);
        for (i = 0; i < 256; i++) begin
            ram[i] = $urandom;
            acc(1, 1, i, ram[i], 0);
        end
        for (i = 128; i < 256; i++) begin
            sfr[i] = $urandom;
            acc(1, 0, i, sfr[i], 0);
        end
        for (i = 0; i < 256; i++) begin
            acc(0, 0, i, 0, i < 128 ? ram[i] : sfr[i]);
            acc(0, 1, i, 0, ram[i]);
        end
        for (b = 0; b < 4; b++) begin
            acc(1, 0, 8'hD0, b << 3, 0);
            sfr[208] = b << 3;
            idle(2);
            check(bank_sel, b);
            for (n = 0; n < 8; n++) acc(0, 2, n, 0, ram[b * 8 + n]);
        end
        for (i = 0; i < 16; i++) begin
            n = $urandom % 128;
            b = $urandom % 2;
            k = 128 + $urandom % 128;
            acc(1, 3, n, b, 0);
            ram[32 + n / 8][n % 8] = b;
            // bit write takes the ram port for its merge next cycle; one spare cycle for margin
            idle(2);
            acc(0, 3, n, 0, b);
            acc(0, 1, 32 + n / 8, 0, ram[32 + n / 8]);
            acc(0, 3, k, 0, sfr[k & 8'hF8]);
        end
        idle(4);
        check(expq.size(), 0);
        erase_addr = $urandom;
        erase_req = 1;
        n = 0;
        for (i = 0; i < 1100 && erase_done !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
            if (flash_we === 1'b1 && n == 0) check(flash_addr, {erase_addr[14:10], 10'h000});
            if (flash_we === 1'b1) n++;
            erase_req = (i == 20);
        end
        check(n, 1024);
        check(erase_done, 1);
        check(erase_busy, 0);
        close_out;
    end
endmodule // tb_internal_data_memory_decode
